// File: general_io_port_control_tb.sv
// Self-checking bench for the port control block
`timescale 1ns/10ps
module general_io_port_control_tb;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic       clock, rst, wake_rst, fwr, frd, bop, bval, dld, old;
  logic       master_clear_input, sleep, ee_in, ee_do, ee_co, tce, wake;
  logic [4:0] faddr, topt;
  logic [7:0] fwd, work, frdata, rd;
  logic [2:0] bsel;
  logic [5:0] alt, pins, pout, poe_n, pu, ext_en, ext_val;
  int         errors, checks, cycles;

  gpio_port_ctrl gpio_port_ctrl_inst (.CLOCK_I(clock), .RST_I(rst),
    .RESET_FROM_WAKE_I(wake_rst), .FILE_ADDR_I(faddr), .FILE_WR_I(fwr),
    .FILE_RD_I(frd), .FILE_WDATA_I(fwd), .FILE_RDATA_O(frdata),
    .BIT_OP_I(bop), .BIT_SEL_I(bsel), .BIT_VAL_I(bval), .DIR_LOAD_I(dld),
    .OPT_LOAD_I(old), .WORK_REG_I(work), .ALT_FUNC_I(alt),
    .MASTER_CLEAR_INPUT_ENABLE_I(master_clear_input), .SLEEP_I(sleep), .PIN_IN_I(pins),
    .PIN_OUT_O(pout), .PIN_OE_N_O(poe_n), .PULLUP_EN_O(pu),
    .EE_DATA_IN_I(ee_in), .EE_DATA_OUT_O(ee_do), .EE_CLOCK_OUT_O(ee_co),
    .TIMER_CLK_EXT_O(tce), .TIMER_OPTIONS_O(topt), .WAKE_RESET_O(wake));

  pin_world pin_world_inst (.clock_i(clock), .pin_out_i(pout),
    .pin_oe_n_i(poe_n), .pullup_en_i(pu), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .ee_data_out_i(ee_do), .pin_level_o(pins),
    .ee_data_level_o(ee_in));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask

  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic do_reset(input logic from_wake);
    wake_rst = from_wake;
    rst = 1'b1;
    tick(16);
    rst = 1'b0;
    wake_rst = 1'b0;
    tick(1);
  endtask

  task automatic load(input logic dir, input logic [7:0] v);
    work = v;
    dld = dir;
    old = !dir;
    tick(1);
    dld = 1'b0;
    old = 1'b0;
    // Idle edge so a following call never re-raises in the same step
    tick(1);
  endtask

  task automatic file_wr(input logic [4:0] a, input logic [7:0] d);
    faddr = a;
    fwd = d;
    fwr = 1'b1;
    tick(1);
    fwr = 1'b0;
    tick(1);
  endtask

  task automatic file_rd(input logic [4:0] a, output logic [7:0] d);
    faddr = a;
    frd = 1'b1;
    tick(1);
    frd = 1'b0;
    d = frdata;
    tick(1);
  endtask

  task automatic bit_op(input logic [2:0] s, input logic v);
    bsel = s;
    bval = v;
    bop = 1'b1;
    tick(1);
    bop = 1'b0;
    tick(1);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    do_reset(1'b1);
    file_rd(gpio_port_pkg::CORE_STATUS_FLAGS_OFS, rd);
    check(rd & 8'h80, 8'h80);
    do_reset(1'b0);
    file_rd(gpio_port_pkg::CORE_STATUS_FLAGS_OFS, rd);
    check(rd & 8'h80, 8'h00);
    file_wr(gpio_port_pkg::CORE_STATUS_FLAGS_OFS, 8'h80);
    file_rd(gpio_port_pkg::CORE_STATUS_FLAGS_OFS, rd);
    check(rd, 8'h80);
    check({2'b00, poe_n}, 8'h3f);
    check({ee_co, ee_do, pout}, 8'hc0);
    check({2'b00, tce, topt}, 8'h3f);
    file_rd(5'h00, rd);
    check(rd, 8'h00);
  endtask

  task automatic t_drive;
    load(1'b0, 8'h1f);
    check({2'b00, tce, topt}, 8'h1f);
    file_wr(gpio_port_pkg::PORT_PIN_DATA_OFS, 8'h3f);
    load(1'b1, 8'h10);
    check({2'b00, poe_n}, 8'h18);
    ext_en = 6'h18;
    file_rd(gpio_port_pkg::PORT_PIN_DATA_OFS, rd);
    check(rd, 8'h27);
    load(1'b0, 8'h3f);
    check({2'b00, poe_n}, 8'h1c);
  endtask

  task automatic t_alt;
    alt = 6'h21;
    master_clear_input = 1'b1;
    load(1'b0, 8'h40);
    file_rd(gpio_port_pkg::PORT_PIN_DATA_OFS, rd);
    check(rd & 8'h2b, 8'h02);
    check({2'b00, pu}, 8'h08);
    alt = 6'h00;
    master_clear_input = 1'b0;
  endtask

  task automatic t_pullup;
    load(1'b1, 8'h3f);
    load(1'b0, 8'h00);
    check({2'b00, pu}, 8'h0b);
    load(1'b1, 8'h3e);
    check({2'b00, pu}, 8'h0a);
    load(1'b0, 8'h40);
    check({2'b00, pu}, 8'h00);
  endtask

  // Pin four is an input held low, so its latch loses the one written
  task automatic t_rmw;
    ext_en = 6'h3e;
    file_wr(gpio_port_pkg::PORT_PIN_DATA_OFS, 8'h10);
    bit_op(3'd0, 1'b1);
    check({ee_co, ee_do, pout}, 8'h01);
    bit_op(3'd7, 1'b1);
    tick(4);
    check({ee_co, ee_do, pout}, 8'h81);
    // Bit op and port write on one edge: the bit op decides the latch
    faddr = gpio_port_pkg::PORT_PIN_DATA_OFS;
    fwd = 8'h3c;
    fwr = 1'b1;
    bsel = 3'h6;
    bval = 1'b1;
    bop = 1'b1;
    tick(1);
    fwr = 1'b0;
    bop = 1'b0;
    tick(1);
    check({ee_co, ee_do, pout}, 8'hc1);
  endtask

  task automatic t_wake;
    load(1'b1, 8'h3f);
    ext_en = 6'h3f;
    ext_val = 6'h02;
    file_rd(gpio_port_pkg::PORT_PIN_DATA_OFS, rd);
    sleep = 1'b1;
    tick(2);
    check({7'h00, wake}, 8'h00);
    ext_val = 6'h12;
    tick(2);
    check({7'h00, wake}, 8'h00);
    ext_val = 6'h00;
    tick(2);
    check({7'h00, wake}, 8'h01);
    load(1'b0, 8'hc0);
    tick(2);
    check({7'h00, wake}, 8'h00);
    sleep = 1'b0;
  endtask

  // ****************************************************************
  // Main sequence and hang guard
  // ****************************************************************
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end

  initial
  begin
    {rst, wake_rst, fwr, frd, bop, bval, dld, old, master_clear_input, sleep} = 10'h000;
    {faddr, fwd, work, bsel} = 24'h00_0000;
    {alt, ext_en, ext_val} = 18'h0_0000;
    t_reset();
    t_drive();
    t_alt();
    t_pullup();
    t_rmw();
    t_wake();
    report_and_stop();
  end
endmodule

// File: gpio_port_ctrl.sv
// General purpose I/O port with direction, options and wake-up logic
`timescale 1ns/10ps
module gpio_port_ctrl
(
  input  wire logic       CLOCK_I,
  input  wire logic       RST_I,
  input  wire logic       RESET_FROM_WAKE_I,
  input  wire logic [4:0] FILE_ADDR_I,
  input  wire logic       FILE_WR_I,
  input  wire logic       FILE_RD_I,
  input  wire logic [7:0] FILE_WDATA_I,
  output logic      [7:0] FILE_RDATA_O,
  input  wire logic       BIT_OP_I,
  input  wire logic [2:0] BIT_SEL_I,
  input  wire logic       BIT_VAL_I,
  input  wire logic       DIR_LOAD_I,
  input  wire logic       OPT_LOAD_I,
  input  wire logic [7:0] WORK_REG_I,
  input  wire logic [5:0] ALT_FUNC_I,
  input  wire logic       MASTER_CLEAR_INPUT_ENABLE_I,
  input  wire logic       SLEEP_I,
  input  wire logic [5:0] PIN_IN_I,
  output logic      [5:0] PIN_OUT_O,
  output logic      [5:0] PIN_OE_N_O,
  output logic      [5:0] PULLUP_EN_O,
  input  wire logic       EE_DATA_IN_I,
  output logic            EE_DATA_OUT_O,
  output logic            EE_CLOCK_OUT_O,
  output logic            TIMER_CLK_EXT_O,
  output logic      [4:0] TIMER_OPTIONS_O,
  output logic            WAKE_RESET_O
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Level seen by the CPU for one port read; alternate pins give zero
  function automatic logic [7:0] port_view(input logic [5:0] pins,
                                           input logic [5:0] alt,
                                           input logic       ee_clk,
                                           input logic       ee_dat);
    logic [7:0] v;
    v      = 8'h00;
    v[5:0] = pins & ~alt;
    v[gpio_port_pkg::EE_CLOCK_BIT] = ee_clk;
    v[gpio_port_pkg::EE_DATA_BIT]  = ee_dat;
    return v;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] latch_q;
  logic [7:0] latch_d;
  logic [5:0] dir_q;
  logic [5:0] dir_d;
  logic [7:0] opt_q;
  logic [7:0] opt_d;
  logic       wake_flag_q;
  logic       wake_flag_d;
  logic [5:0] last_read_q;
  logic [5:0] last_read_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       wake_q;
  logic       wake_d;

  logic [5:0] alt_mask;
  logic [7:0] pin_view;
  logic [5:0] eff_input;
  logic [5:0] wake_mask;
  logic       wake_mismatch;
  logic       port_rd;
  logic       port_wr;
  logic       stat_wr;

  // ****************************************************************
  // Pin conditioning
  // ****************************************************************
  always_comb
  begin
    alt_mask = ALT_FUNC_I;
    // The master-clear function takes pin three away from the port
    alt_mask[gpio_port_pkg::PORT_PIN_THREE] =
      ALT_FUNC_I[gpio_port_pkg::PORT_PIN_THREE] | MASTER_CLEAR_INPUT_ENABLE_I;
    // Inputs are sampled live at the read, nothing holds them
    pin_view = port_view(PIN_IN_I, alt_mask,
                         latch_q[gpio_port_pkg::EE_CLOCK_BIT],
                         EE_DATA_IN_I);
    eff_input = dir_q;
    eff_input[gpio_port_pkg::PORT_PIN_THREE] = 1'b1;
    if (opt_q[gpio_port_pkg::TIMER_CLOCK_SOURCE_BIT])
    begin
      eff_input[gpio_port_pkg::PORT_PIN_TWO] = 1'b1;
    end
    port_rd = FILE_RD_I
              && (FILE_ADDR_I == gpio_port_pkg::PORT_PIN_DATA_OFS);
    port_wr = FILE_WR_I
              && (FILE_ADDR_I == gpio_port_pkg::PORT_PIN_DATA_OFS);
    stat_wr = FILE_WR_I
              && (FILE_ADDR_I == gpio_port_pkg::CORE_STATUS_FLAGS_OFS);
  end

  // ****************************************************************
  // Pin drivers and shared pull-ups
  // ****************************************************************
  always_comb
  begin
    PIN_OUT_O  = latch_q[5:0];
    // Port gives way to alternate functions; no contention guard exists
    PIN_OE_N_O = eff_input | alt_mask;
    PULLUP_EN_O = 6'h00;
    if (!opt_q[gpio_port_pkg::WEAK_PULLUP_DISABLE_BIT])
    begin
      PULLUP_EN_O = gpio_port_pkg::SHARED_FUNC_MASK
                    & eff_input;
    end
    if (MASTER_CLEAR_INPUT_ENABLE_I)
    begin
      PULLUP_EN_O[gpio_port_pkg::PORT_PIN_THREE] = 1'b1;
    end
  end

  // ****************************************************************
  // Wake-up on pin change
  // ****************************************************************
  always_comb
  begin
    wake_mask = 6'h00;
    if (!opt_q[gpio_port_pkg::WAKE_ON_CHANGE_DISABLE_BIT])
    begin
      wake_mask = gpio_port_pkg::SHARED_FUNC_MASK
                  & eff_input;
    end
    if (MASTER_CLEAR_INPUT_ENABLE_I)
    begin
      wake_mask[gpio_port_pkg::PORT_PIN_THREE] = 1'b0;
    end
    // Compared against the last read, so software must read before sleep
    wake_mismatch = |((PIN_IN_I ^ last_read_q) & wake_mask);
    wake_d = SLEEP_I && wake_mismatch;
  end

  // ****************************************************************
  // Register next values
  // ****************************************************************
  always_comb
  begin
    latch_d     = latch_q;
    dir_d       = dir_q;
    opt_d       = opt_q;
    wake_flag_d = wake_flag_q;
    last_read_d = last_read_q;
    rdata_d     = rdata_q;
    if (port_wr)
    begin
      latch_d = FILE_WDATA_I;
    end
    if (BIT_OP_I)
    begin
      // Whole port is read back, so input pins overwrite their latches
      latch_d = pin_view;
      latch_d[BIT_SEL_I] = BIT_VAL_I;
      last_read_d = pin_view[5:0];
    end
    if (DIR_LOAD_I)
    begin
      dir_d = WORK_REG_I[5:0];
    end
    if (OPT_LOAD_I)
    begin
      opt_d = WORK_REG_I;
    end
    if (stat_wr)
    begin
      wake_flag_d = FILE_WDATA_I[gpio_port_pkg::WAKE_RESET_FLAG_BIT];
    end
    if (FILE_RD_I)
    begin
      rdata_d = 8'h00;
      if (port_rd)
      begin
        rdata_d     = pin_view;
        last_read_d = pin_view[5:0];
      end
      else if (FILE_ADDR_I == gpio_port_pkg::CORE_STATUS_FLAGS_OFS)
      begin
        rdata_d[gpio_port_pkg::WAKE_RESET_FLAG_BIT] = wake_flag_q;
      end
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      latch_q     <= gpio_port_pkg::PORT_LATCH_RST;
      dir_q       <= gpio_port_pkg::PIN_DIRECTION_CONTROL_RST;
      opt_q       <= gpio_port_pkg::TIMER_PORT_OPTIONS_RST;
      // Cause is given by the reset source while reset is held
      wake_flag_q <= RESET_FROM_WAKE_I;
      last_read_q <= 6'h00;
      rdata_q     <= 8'h00;
      wake_q      <= 1'b0;
    end
    else
    begin
      latch_q     <= latch_d;
      dir_q       <= dir_d;
      opt_q       <= opt_d;
      wake_flag_q <= wake_flag_d;
      last_read_q <= last_read_d;
      rdata_q     <= rdata_d;
      wake_q      <= wake_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign FILE_RDATA_O    = rdata_q;
  assign EE_DATA_OUT_O   = latch_q[gpio_port_pkg::EE_DATA_BIT];
  assign EE_CLOCK_OUT_O  = latch_q[gpio_port_pkg::EE_CLOCK_BIT];
  assign TIMER_CLK_EXT_O =
    opt_q[gpio_port_pkg::TIMER_CLOCK_SOURCE_BIT];
  assign TIMER_OPTIONS_O = opt_q[4:0];
  assign WAKE_RESET_O    = wake_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_read_pins: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    port_rd |=> FILE_RDATA_O[5:0] == ($past(PIN_IN_I) & ~$past(alt_mask)))
    else $error("port read did not return pin levels");

  a_reset_dirs: assert property (
    @(posedge CLOCK_I)
    RST_I |=> dir_q == gpio_port_pkg::PIN_DIRECTION_CONTROL_RST
    && PIN_OE_N_O == gpio_port_pkg::PIN_DIRECTION_CONTROL_RST)
    else $error("reset did not make all pins inputs");

  a_pin3_input: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    PIN_OE_N_O[3])
    else $error("pin three is driving");

  a_alt_zero: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    port_rd |=> (FILE_RDATA_O[5:0] & $past(alt_mask)) == 6'h00)
    else $error("alternate pin read nonzero");

  a_pullup_pins: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    PULLUP_EN_O[2] == 1'b0 && PULLUP_EN_O[4] == 1'b0
    && PULLUP_EN_O[5] == 1'b0)
    else $error("pull-up on an unsupported pin");

  a_master_clear_input_pullup: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    MASTER_CLEAR_INPUT_ENABLE_I |-> PULLUP_EN_O[3] && !wake_mask[3])
    else $error("master-clear pin pull-up or wake wrong");

  a_wake_off: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    opt_q[7] |=> !WAKE_RESET_O)
    else $error("wake raised while disabled");

  a_pullup_off: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    opt_q[6] && !MASTER_CLEAR_INPUT_ENABLE_I |-> PULLUP_EN_O == 6'h00)
    else $error("pull-up on while disabled");

  a_drive_latch: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    !dir_q[0] && !alt_mask[0] |-> !PIN_OE_N_O[0]
    && PIN_OUT_O[0] == latch_q[0])
    else $error("output pin not driving latch");

  a_dir_load: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    DIR_LOAD_I |=> dir_q == $past(WORK_REG_I[5:0]))
    else $error("direction register not loaded");

  a_latch_hold: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    !port_wr && !BIT_OP_I |=> latch_q == $past(latch_q))
    else $error("output latch changed without a write");

  a_port_write: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    port_wr && !BIT_OP_I
    |=> {EE_CLOCK_OUT_O, EE_DATA_OUT_O, PIN_OUT_O} == $past(FILE_WDATA_I))
    else $error("port write did not reach all eight latches");

  a_rmw_all: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    BIT_OP_I && BIT_SEL_I != 3'h0 |=> latch_q[0] == $past(pin_view[0]))
    else $error("bit op did not rewrite other latches");

  a_rmw_bit: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    BIT_OP_I |=> latch_q[$past(BIT_SEL_I)] == $past(BIT_VAL_I))
    else $error("bit op did not set the selected bit");

  a_wake_flag: assert property (
    @(posedge CLOCK_I)
    RST_I ##1 !RST_I |-> wake_flag_q == $past(RESET_FROM_WAKE_I))
    else $error("wake flag not set from reset cause");

  a_status_read: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    FILE_RD_I && FILE_ADDR_I == gpio_port_pkg::CORE_STATUS_FLAGS_OFS
    |=> FILE_RDATA_O == {$past(wake_flag_q), 7'h00})
    else $error("status read did not show the wake flag");

  a_timer_source: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    OPT_LOAD_I |=> TIMER_CLK_EXT_O == $past(WORK_REG_I[5])
    && TIMER_OPTIONS_O == $past(WORK_REG_I[4:0]))
    else $error("options register not loaded");

  a_pin2_forced: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    opt_q[5] |-> PIN_OE_N_O[2] && !PULLUP_EN_O[2])
    else $error("pin two driving with external timer clock");

  a_out_no_pull: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    !dir_q[0] |-> !PULLUP_EN_O[0] && !wake_mask[0])
    else $error("output pin has pull-up or wake");

  a_wake_cause: assert property (
    @(posedge CLOCK_I) disable iff (RST_I)
    SLEEP_I && !opt_q[7] && wake_mask[0] && PIN_IN_I[0] != last_read_q[0]
    |=> WAKE_RESET_O)
    else $error("pin change in sleep did not wake");

endmodule

// File: gpio_port_pkg.sv
// Package with register map, field positions and reset values of the port
package gpio_port_pkg;

  // ****************************************************************
  // File register offsets
  // ****************************************************************
  localparam logic [4:0] CORE_STATUS_FLAGS_OFS = 5'h03;
  localparam logic [4:0] PORT_PIN_DATA_OFS     = 5'h06;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int WAKE_RESET_FLAG_BIT        = 7;
  localparam int WAKE_ON_CHANGE_DISABLE_BIT = 7;
  localparam int WEAK_PULLUP_DISABLE_BIT    = 6;
  localparam int TIMER_CLOCK_SOURCE_BIT     = 5;
  localparam int EE_CLOCK_BIT               = 7;
  localparam int EE_DATA_BIT                = 6;
  localparam int PORT_PIN_ZERO              = 0;
  localparam int PORT_PIN_ONE               = 1;
  localparam int PORT_PIN_TWO               = 2;
  localparam int PORT_PIN_THREE             = 3;
  localparam int PORT_PINS                  = 6;

  // Pins that carry the shared pull-up and wake-on-change functions
  localparam logic [5:0] SHARED_FUNC_MASK = 6'h0b;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] TIMER_PORT_OPTIONS_RST    = 8'hff;
  localparam logic [5:0] PIN_DIRECTION_CONTROL_RST = 6'h3f;
  localparam logic [7:0] PORT_LATCH_RST            = 8'hc0;

endpackage

// File: pin_world.sv
// Model of the outside world at the port pins and the EEPROM data line
`timescale 1ns/10ps
module pin_world
(
  input  wire logic       clock_i,
  input  wire logic [5:0] pin_out_i,
  input  wire logic [5:0] pin_oe_n_i,
  input  wire logic [5:0] pullup_en_i,
  input  wire logic [5:0] ext_en_i,
  input  wire logic [5:0] ext_val_i,
  input  wire logic       ee_data_out_i,
  output logic      [5:0] pin_level_o,
  output logic            ee_data_level_o
);
  // ****************************************************************
  // Wire resolution
  // ****************************************************************
  logic [5:0] float_q = 6'h00;

  // Undriven lines flip every cycle so a stale level is never read back
  always @(negedge clock_i)
  begin
    float_q <= ~pin_level_o;
  end

  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      if (!pin_oe_n_i[i])
        pin_level_o[i] = pin_out_i[i];
      else if (ext_en_i[i])
        pin_level_o[i] = ext_val_i[i];
      else if (pullup_en_i[i])
        pin_level_o[i] = 1'b1;
      else
        pin_level_o[i] = float_q[i];
    end
  end

  // Open-drain line with its pull-up
  assign ee_data_level_o = ee_data_out_i ? 1'b1 : 1'b0;
endmodule
